// ### seek_feat_pkg.sv
// =============================================================
// Shared constants
package seek_feat_pkg;

  // =============================================================
  // Byte offsets
  localparam logic [7:0] OFS_FEATURE = 8'h00;
  localparam logic [7:0] OFS_SECCNT = 8'h04;
  localparam logic [7:0] OFS_SECNUM = 8'h08;
  localparam logic [7:0] OFS_CYLLO = 8'h0C;
  localparam logic [7:0] OFS_CYLHI = 8'h10;
  localparam logic [7:0] OFS_DEVHEAD = 8'h14;
  localparam logic [7:0] OFS_COMMAND = 8'h18;
  localparam logic [7:0] OFS_CONTROL = 8'h1C;
  localparam logic [7:0] OFS_CONFIG = 8'h20;

  // =============================================================
  // Field positions
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_ERR = 0;
  localparam int ERR_ABRT = 2;
  localparam int ERR_IDNF = 4;
  localparam int CTRL_SRST = 2;
  localparam int DH_LBA = 6;

  // =============================================================
  // Command and subcommand codes
  localparam logic [3:0] CMD_SEEK_NIB = 4'h7;
  localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
  localparam logic [7:0] SF_8BIT_ON = 8'h01;
  localparam logic [7:0] SF_WC_ON = 8'h02;
  localparam logic [7:0] SF_XFER = 8'h03;
  localparam logic [7:0] SF_APM_ON = 8'h05;
  localparam logic [7:0] SF_EXT_ON = 8'h09;
  localparam logic [7:0] SF_PL1_ON = 8'h0A;
  localparam logic [7:0] SF_ECC_LONG = 8'h44;
  localparam logic [7:0] SF_RLA_OFF = 8'h55;
  localparam logic [7:0] SF_POR_OFF = 8'h66;
  localparam logic [7:0] SF_NOP_69 = 8'h69;
  localparam logic [7:0] SF_8BIT_OFF = 8'h81;
  localparam logic [7:0] SF_WC_OFF = 8'h82;
  localparam logic [7:0] SF_APM_OFF = 8'h85;
  localparam logic [7:0] SF_EXT_OFF = 8'h89;
  localparam logic [7:0] SF_PL1_OFF = 8'h8A;
  localparam logic [7:0] SF_NOP_96 = 8'h96;
  localparam logic [7:0] SF_NOP_97 = 8'h97;
  localparam logic [7:0] SF_CURRENT = 8'h9A;
  localparam logic [7:0] SF_RLA_ON = 8'hAA;
  localparam logic [7:0] SF_CHK4_LONG = 8'hBB;
  localparam logic [7:0] SF_POR_ON = 8'hCC;

  // =============================================================
  // Mode and level codes
  localparam logic [4:0] XT_DEFAULT = 5'h00;
  localparam logic [4:0] XT_FLOW = 5'h01;
  localparam logic [2:0] XM_DEFAULT = 3'h0;
  localparam logic [2:0] XM_NO_IORDY = 3'h1;
  localparam logic [2:0] PIO_NEEDS_IORDY = 3'h3;
  localparam logic [7:0] APM_RSVD_LO = 8'h00;
  localparam logic [7:0] APM_RSVD_HI = 8'hFF;
  localparam logic [7:0] APM_MIN_STBY = 8'h01;
  localparam logic [7:0] APM_NO_STBY = 8'h80;
  localparam logic [7:0] LONG_CHECK_BYTES = 8'h04;

  // =============================================================
  // Reset values
  localparam logic [7:0] APM_LEVEL_RST = 8'hFE;
  localparam logic [2:0] PIO_RST = 3'h0;
  localparam logic [7:0] TF_RST = 8'h00;

  typedef struct packed {
    logic por_soft;
    logic ecc_long;
    logic rla;
    logic ext_pwr;
    logic pl1;
    logic apm_en;
    logic [7:0] apm_level;
    logic [7:0] cur_limit;
    logic wcache;
    logic iordy;
    logic [2:0] pio;
    logic eight_bit;
  } cfg_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_FLUSH = 2'b11,
    ST_DONE = 2'b10
  } exec_e;

endpackage

// ### addr_range_check.sv
`timescale 1ns/1ns
// =============================================================
// Registered capacity check
module addr_range_check #(
  parameter logic [15:0] NUM_CYL = 16'h0400,
  parameter logic [4:0] NUM_HEADS = 5'h10,
  parameter logic [7:0] NUM_SECT = 8'h20,
  parameter logic [28:0] TOTAL_LBA = 29'h0080_0000
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Address fields
  input wire logic lba_mode_i,
  input wire logic [27:0] lba_i,
  input wire logic [15:0] cyl_i,
  input wire logic [3:0] head_i,
  input wire logic [7:0] sector_i,
  // Result
  output logic in_range_o
);

  function automatic logic below(input logic [28:0] val, input logic [28:0] lim);
    below = val < lim;
  endfunction

  logic chs_ok;
  logic lba_ok;

  assign lba_ok = below(29'(lba_i), TOTAL_LBA);
  // Sectors count from one in CHS addressing
  assign chs_ok = below(29'(cyl_i), 29'(NUM_CYL)) &&
                  below(29'(head_i), 29'(NUM_HEADS)) &&
                  (sector_i != 8'h00) &&
                  !below(29'(NUM_SECT), 29'(sector_i));

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_range_o <= 1'b0;
    end else begin
      in_range_o <= lba_mode_i ? lba_ok : chs_ok;
    end
  end

endmodule // addr_range_check

// ### seek_feature_exec.sv
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
// What this block does
// - Seek range-checks address, reports error, no media
// - Set features decodes feature/count, aborts invalid
// - 01h/81h toggle 8-bit, no IOIS16
// - 02h/82h write cache; flush before done
// - Transfer code: type bits 7:3, mode 2:0
// - Decode default, no-IORDY default, flow-control PIO
// - Exactly one PIO mode, host may change
// - Code 00h default PIO; 01h also IORDY off
// - All modes up to highest supported accepted
// - IORDY driven whenever PIO mode three up
// - 05h adopts power level 01h..FEh
// - Classify power levels; 00h/FFh reserved
// - Level 80h up forbids own standby
// - 85h disables APM, or aborts unsupported
// - Power level 1 and extended power toggles
// - Look-ahead toggles; defaults as 55h, BBh
// - Long commands: 4 bytes or ECC bytes
// - 9Ah sets current limit to the count, unscaled
// - 9Ah returns min/max in cylinder registers
// - Clamp current; power-on default maximum
// - 66h/CCh control soft reset defaults reload
// - 69h, 96h, 97h accepted as no-ops
module seek_feature_exec #(
  parameter logic [2:0] MAX_PIO = 3'h4,
  parameter logic [2:0] PIO_DEFAULT = 3'h0,
  parameter bit IORDY_DIS_OK = 1'b1,
  parameter bit HAS_WCACHE = 1'b1,
  parameter bit HAS_EXT_PWR = 1'b1,
  parameter bit APM_OFF_OK = 1'b1,
  parameter logic [7:0] CUR_MIN = 8'h05,
  parameter logic [7:0] CUR_MAX = 8'h19,
  parameter logic [7:0] ECC_BYTES = 8'h04,
  parameter logic [15:0] NUM_CYL = 16'h0400,
  parameter logic [4:0] NUM_HEADS = 5'h10,
  parameter logic [7:0] NUM_SECT = 8'h20,
  parameter logic [28:0] TOTAL_LBA = 29'h0080_0000
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Cache flush handshake
  output logic flush_req_o,
  input wire logic flush_done_i,
  // Card settings
  output logic data_lo_only_o,
  output logic iois16_allow_o,
  output logic wcache_en_o,
  output logic [2:0] pio_mode_o,
  output logic iordy_en_o,
  output logic apm_en_o,
  output logic [7:0] apm_level_o,
  output logic [1:0] apm_band_o,
  output logic standby_allow_o,
  output logic pl1_en_o,
  output logic ext_pwr_en_o,
  output logic rla_en_o,
  output logic [7:0] long_extra_bytes_o,
  output logic [7:0] cur_limit_o,
  // Execution status
  output logic busy_o,
  output logic cmd_done_o
);

  // Power-on values as after 55h and BBh
  localparam seek_feat_pkg::cfg_s CFG_RST = '{
    por_soft: 1'b1, ecc_long: 1'b0, rla: 1'b0, ext_pwr: 1'b0,
    pl1: HAS_EXT_PWR, apm_en: 1'b0, apm_level: seek_feat_pkg::APM_LEVEL_RST,
    cur_limit: CUR_MAX, wcache: 1'b0, iordy: 1'b1,
    pio: seek_feat_pkg::PIO_RST, eight_bit: 1'b0};

  // =============================================================
  // Bus front end
  logic addr_ph;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic addr_ok_q;
  logic [31:0] hrdata_q;
  logic wr_en;
  logic [7:0] feat_q;
  logic [7:0] seccnt_q;
  logic [7:0] secnum_q;
  logic [7:0] cyllo_q;
  logic [7:0] cylhi_q;
  logic [7:0] devhead_q;
  logic [7:0] cmd_q;
  logic [7:0] err_q;
  logic srst_q;
  logic srst_pulse;
  logic start;
  seek_feat_pkg::cfg_s cfg_q;
  seek_feat_pkg::cfg_s cfg_n;
  seek_feat_pkg::exec_e state_q;
  logic in_range;
  logic abort;
  logic idnf;
  logic need_flush;
  logic cur_resp;
  logic busy;

  assign addr_ph = hsel_i && htrans_i[1] && hready_i;
  // Reads take one wait state so a write just before is seen
  assign hreadyout_o = !rd_pend_q;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      addr_ok_q <= 1'b0;
    end else begin
      wr_pend_q <= addr_ph && hwrite_i && (hsize_i == 3'h2);
      rd_pend_q <= addr_ph && !hwrite_i;
      if (addr_ph) begin
        addr_q <= haddr_i[7:0];
        addr_ok_q <= (haddr_i[31:8] == 24'h000000) && (haddr_i[1:0] == 2'h0);
      end
    end
  end

  assign wr_en = wr_pend_q && addr_ok_q;
  assign busy = (state_q == seek_feat_pkg::ST_EXEC) || (state_q == seek_feat_pkg::ST_FLUSH);
  assign start = wr_en && (addr_q == seek_feat_pkg::OFS_COMMAND) && !busy && !srst_q;
  assign srst_pulse = wr_en && (addr_q == seek_feat_pkg::OFS_CONTROL) && hwdata_i[seek_feat_pkg::CTRL_SRST];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      hrdata_q <= 32'h0000_0000;
      if (addr_ok_q) begin
        unique case (addr_q)
          seek_feat_pkg::OFS_FEATURE: hrdata_q <= 32'(err_q);
          seek_feat_pkg::OFS_SECCNT: hrdata_q <= 32'(seccnt_q);
          seek_feat_pkg::OFS_SECNUM: hrdata_q <= 32'(secnum_q);
          seek_feat_pkg::OFS_CYLLO: hrdata_q <= 32'(cyllo_q);
          seek_feat_pkg::OFS_CYLHI: hrdata_q <= 32'(cylhi_q);
          seek_feat_pkg::OFS_DEVHEAD: hrdata_q <= 32'(devhead_q);
          seek_feat_pkg::OFS_COMMAND: begin
            hrdata_q[seek_feat_pkg::ST_BSY] <= busy || srst_q;
            hrdata_q[seek_feat_pkg::ST_DRDY] <= !busy && !srst_q;
            hrdata_q[seek_feat_pkg::ST_ERR] <= |err_q;
          end
          seek_feat_pkg::OFS_CONTROL: hrdata_q[seek_feat_pkg::CTRL_SRST] <= srst_q;
          seek_feat_pkg::OFS_CONFIG: hrdata_q <= {cfg_q.cur_limit, cfg_q.apm_level, 4'h0,
            cfg_q.por_soft, cfg_q.ecc_long, cfg_q.rla, cfg_q.ext_pwr, cfg_q.pl1, cfg_q.apm_en,
            cfg_q.wcache, iordy_en_o, cfg_q.pio, cfg_q.eight_bit};
          default: ;
        endcase
      end
    end
  end

  // =============================================================
  // Task file; writes ignored while busy
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      feat_q <= seek_feat_pkg::TF_RST;
      seccnt_q <= seek_feat_pkg::TF_RST;
      secnum_q <= seek_feat_pkg::TF_RST;
      cyllo_q <= seek_feat_pkg::TF_RST;
      cylhi_q <= seek_feat_pkg::TF_RST;
      devhead_q <= seek_feat_pkg::TF_RST;
      cmd_q <= seek_feat_pkg::TF_RST;
    end else if (state_q == seek_feat_pkg::ST_EXEC && cur_resp && !abort) begin
      cyllo_q <= CUR_MIN;
      cylhi_q <= CUR_MAX;
    end else if (wr_en && !busy) begin
      unique case (addr_q)
        seek_feat_pkg::OFS_FEATURE: feat_q <= hwdata_i[7:0];
        seek_feat_pkg::OFS_SECCNT: seccnt_q <= hwdata_i[7:0];
        seek_feat_pkg::OFS_SECNUM: secnum_q <= hwdata_i[7:0];
        seek_feat_pkg::OFS_CYLLO: cyllo_q <= hwdata_i[7:0];
        seek_feat_pkg::OFS_CYLHI: cylhi_q <= hwdata_i[7:0];
        seek_feat_pkg::OFS_DEVHEAD: devhead_q <= hwdata_i[7:0];
        seek_feat_pkg::OFS_COMMAND: cmd_q <= srst_q ? cmd_q : hwdata_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      srst_q <= 1'b0;
    end else if (wr_en && addr_q == seek_feat_pkg::OFS_CONTROL) begin
      srst_q <= hwdata_i[seek_feat_pkg::CTRL_SRST];
    end
  end

  // =============================================================
  // Address capacity check
  addr_range_check #(
    .NUM_CYL(NUM_CYL),
    .NUM_HEADS(NUM_HEADS),
    .NUM_SECT(NUM_SECT),
    .TOTAL_LBA(TOTAL_LBA)
  ) u_range (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .lba_mode_i(devhead_q[seek_feat_pkg::DH_LBA]),
    .lba_i({devhead_q[3:0], cylhi_q, cyllo_q, secnum_q}),
    .cyl_i({cylhi_q, cyllo_q}),
    .head_i(devhead_q[3:0]),
    .sector_i(secnum_q),
    .in_range_o(in_range)
  );

  function automatic logic [7:0] clamp_current(input logic [7:0] req);
    if (req < CUR_MIN) begin
      clamp_current = CUR_MIN;
    end else if (req > CUR_MAX) begin
      clamp_current = CUR_MAX;
    end else begin
      clamp_current = req;
    end
  endfunction

  // =============================================================
  // Command decode
  always_comb begin
    cfg_n = cfg_q;
    abort = 1'b0;
    idnf = 1'b0;
    need_flush = 1'b0;
    cur_resp = 1'b0;
    if (cmd_q[7:4] == seek_feat_pkg::CMD_SEEK_NIB) begin
      // no media action, only the range
      idnf = !in_range;
    end else if (cmd_q == seek_feat_pkg::CMD_SET_FEATURES) begin
      unique case (feat_q)
        seek_feat_pkg::SF_8BIT_ON: cfg_n.eight_bit = 1'b1;
        seek_feat_pkg::SF_8BIT_OFF: cfg_n.eight_bit = 1'b0;
        seek_feat_pkg::SF_WC_ON: begin
          if (HAS_WCACHE) cfg_n.wcache = 1'b1;
          else abort = 1'b1;
        end
        seek_feat_pkg::SF_WC_OFF: begin
          if (HAS_WCACHE) begin
            cfg_n.wcache = 1'b0;
            need_flush = cfg_q.wcache;
          end else begin
            abort = 1'b1;
          end
        end
        seek_feat_pkg::SF_XFER: begin
          unique case (seccnt_q[7:3])
            // default type, with or without IORDY
            seek_feat_pkg::XT_DEFAULT: begin
              // zero code default, one drops IORDY
              if (seccnt_q[2:0] == seek_feat_pkg::XM_DEFAULT) begin
                cfg_n.pio = PIO_DEFAULT;
                cfg_n.iordy = 1'b1;
              end else if (seccnt_q[2:0] == seek_feat_pkg::XM_NO_IORDY && IORDY_DIS_OK) begin
                cfg_n.pio = PIO_DEFAULT;
                cfg_n.iordy = 1'b0;
              end else begin
                abort = 1'b1;
              end
            end
            seek_feat_pkg::XT_FLOW: begin
              // every mode up to the highest
              if (seccnt_q[2:0] <= MAX_PIO) begin
                cfg_n.pio = seccnt_q[2:0];
                cfg_n.iordy = 1'b1;
              end else begin
                abort = 1'b1;
              end
            end
            default: abort = 1'b1;
          endcase
        end
        seek_feat_pkg::SF_APM_ON: begin
          if (seccnt_q == seek_feat_pkg::APM_RSVD_LO || seccnt_q == seek_feat_pkg::APM_RSVD_HI) begin
            abort = 1'b1;
          end else begin
            cfg_n.apm_en = 1'b1;
            cfg_n.apm_level = seccnt_q;
          end
        end
        seek_feat_pkg::SF_APM_OFF: begin
          if (APM_OFF_OK) cfg_n.apm_en = 1'b0;
          else abort = 1'b1;
        end
        // power level 1 and extended power
        seek_feat_pkg::SF_PL1_ON: cfg_n.pl1 = 1'b1;
        seek_feat_pkg::SF_PL1_OFF: cfg_n.pl1 = 1'b0;
        seek_feat_pkg::SF_EXT_ON: begin
          if (HAS_EXT_PWR) cfg_n.ext_pwr = 1'b1;
          else abort = 1'b1;
        end
        seek_feat_pkg::SF_EXT_OFF: begin
          if (HAS_EXT_PWR) cfg_n.ext_pwr = 1'b0;
          else abort = 1'b1;
        end
        seek_feat_pkg::SF_RLA_OFF: cfg_n.rla = 1'b0;
        seek_feat_pkg::SF_RLA_ON: cfg_n.rla = 1'b1;
        seek_feat_pkg::SF_ECC_LONG: cfg_n.ecc_long = 1'b1;
        seek_feat_pkg::SF_CHK4_LONG: cfg_n.ecc_long = 1'b0;
        seek_feat_pkg::SF_POR_OFF: cfg_n.por_soft = 1'b0;
        seek_feat_pkg::SF_POR_ON: cfg_n.por_soft = 1'b1;
        seek_feat_pkg::SF_NOP_69, seek_feat_pkg::SF_NOP_96, seek_feat_pkg::SF_NOP_97: ;
        seek_feat_pkg::SF_CURRENT: begin
          cfg_n.cur_limit = clamp_current(seccnt_q);
          cur_resp = 1'b1;
        end
        default: abort = 1'b1;
      endcase
    end else begin
      abort = 1'b1;
    end
  end

  // =============================================================
  // Execution sequence
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= seek_feat_pkg::ST_IDLE;
    end else if (srst_pulse) begin
      state_q <= seek_feat_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        seek_feat_pkg::ST_IDLE: if (start) state_q <= seek_feat_pkg::ST_EXEC;
        seek_feat_pkg::ST_EXEC: state_q <= (need_flush && !abort) ? seek_feat_pkg::ST_FLUSH
                                                                    : seek_feat_pkg::ST_DONE;
        seek_feat_pkg::ST_FLUSH: if (flush_done_i) state_q <= seek_feat_pkg::ST_DONE;
        seek_feat_pkg::ST_DONE: state_q <= start ? seek_feat_pkg::ST_EXEC : seek_feat_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_q <= 8'h00;
    end else if (srst_pulse || start) begin
      err_q <= 8'h00;
    end else if (state_q == seek_feat_pkg::ST_EXEC) begin
      err_q[seek_feat_pkg::ERR_ABRT] <= abort;
      err_q[seek_feat_pkg::ERR_IDNF] <= idnf;
    end
  end

  // Aborts change no setting
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= CFG_RST;
    end else if (srst_pulse) begin
      if (cfg_q.por_soft) cfg_q <= CFG_RST;
    end else if (state_q == seek_feat_pkg::ST_EXEC && !abort) begin
      cfg_q <= cfg_n;
    end
  end

  // =============================================================
  // Outputs
  // busy held until completion
  assign busy_o = busy || srst_q;
  assign cmd_done_o = (state_q == seek_feat_pkg::ST_DONE);
  assign flush_req_o = (state_q == seek_feat_pkg::ST_FLUSH);
  assign data_lo_only_o = cfg_q.eight_bit;
  assign iois16_allow_o = !cfg_q.eight_bit;
  assign wcache_en_o = cfg_q.wcache;
  assign pio_mode_o = cfg_q.pio;
  assign iordy_en_o = cfg_q.iordy || (cfg_q.pio >= seek_feat_pkg::PIO_NEEDS_IORDY);
  assign apm_en_o = cfg_q.apm_en;
  assign apm_level_o = cfg_q.apm_level;
  assign apm_band_o = {cfg_q.apm_level >= seek_feat_pkg::APM_NO_STBY,
    (cfg_q.apm_level != seek_feat_pkg::APM_MIN_STBY) && (cfg_q.apm_level != seek_feat_pkg::APM_NO_STBY)};
  // no own standby at high levels
  assign standby_allow_o = !cfg_q.apm_en || (cfg_q.apm_level < seek_feat_pkg::APM_NO_STBY);
  assign pl1_en_o = cfg_q.pl1;
  assign ext_pwr_en_o = cfg_q.ext_pwr;
  assign rla_en_o = cfg_q.rla;
  assign long_extra_bytes_o = cfg_q.ecc_long ? ECC_BYTES : seek_feat_pkg::LONG_CHECK_BYTES;
  assign cur_limit_o = cfg_q.cur_limit;

endmodule // seek_feature_exec

// ### seek_feature_exec_checker.sv
`timescale 1ns/1ns
// ============================================================
// Port checker
module seek_feature_exec_checker #(
  parameter logic [2:0] MAX_PIO = 3'h4,
  parameter logic [7:0] CUR_MIN = 8'h05,
  parameter logic [7:0] CUR_MAX = 8'h19
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic flush_req_o,
  input wire logic flush_done_i,
  input wire logic data_lo_only_o,
  input wire logic iois16_allow_o,
  input wire logic [2:0] pio_mode_o,
  input wire logic iordy_en_o,
  input wire logic apm_en_o,
  input wire logic [7:0] apm_level_o,
  input wire logic [1:0] apm_band_o,
  input wire logic standby_allow_o,
  input wire logic [7:0] cur_limit_o,
  input wire logic busy_o,
  input wire logic cmd_done_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  AST_IORDY_FAST_PIO: assert property (pio_mode_o >= 3'h3 |-> iordy_en_o)
    else $error("iordy off at fast pio");
  AST_EIGHT_BIT_LANES: assert property (data_lo_only_o != iois16_allow_o)
    else $error("iois16 allowed in 8-bit mode");
  AST_NO_OWN_STANDBY: assert property (apm_en_o && apm_level_o >= 8'h80 |-> !standby_allow_o)
    else $error("standby allowed at high level");
  AST_APM_BAND: assert property (apm_en_o |-> apm_band_o == ((apm_level_o == 8'h01) ? 2'h0 :
    (apm_level_o < 8'h80) ? 2'h1 : (apm_level_o == 8'h80) ? 2'h2 : 2'h3))
    else $error("power band wrong");
  AST_APM_LEVEL_LEGAL: assert property (apm_en_o |-> apm_level_o != 8'h00 && apm_level_o != 8'hFF)
    else $error("reserved power level adopted");
  AST_PIO_RANGE: assert property (pio_mode_o <= MAX_PIO)
    else $error("pio mode beyond maximum");
  AST_CUR_CLAMP: assert property (cur_limit_o >= CUR_MIN && cur_limit_o <= CUR_MAX)
    else $error("current limit not clamped");
  AST_FLUSH_THEN_DONE: assert property (flush_req_o && flush_done_i |=> cmd_done_o && !flush_req_o)
    else $error("no completion after flush");
  AST_FLUSH_BUSY: assert property (flush_req_o |-> busy_o && !cmd_done_o)
    else $error("completion during flush");
  AST_DONE_AFTER_BUSY: assert property (cmd_done_o |-> !busy_o && $past(busy_o))
    else $error("completion without busy");

  COV_FLUSH: cover property (flush_req_o ##1 !flush_req_o);
  COV_BAND_MIN_NO_STBY: cover property (apm_en_o && apm_band_o == 2'h2);
  COV_PIO_TOP: cover property (pio_mode_o == 3'h4);
endmodule // seek_feature_exec_checker

bind seek_feature_exec seek_feature_exec_checker #(.MAX_PIO(MAX_PIO), .CUR_MIN(CUR_MIN), .CUR_MAX(CUR_MAX))
  i_seek_feature_exec_checker (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .flush_req_o(flush_req_o),
  .flush_done_i(flush_done_i), .data_lo_only_o(data_lo_only_o), .iois16_allow_o(iois16_allow_o),
  .pio_mode_o(pio_mode_o), .iordy_en_o(iordy_en_o), .apm_en_o(apm_en_o), .apm_level_o(apm_level_o),
  .apm_band_o(apm_band_o), .standby_allow_o(standby_allow_o), .cur_limit_o(cur_limit_o),
  .busy_o(busy_o), .cmd_done_o(cmd_done_o));

// ### flush_model.sv
`timescale 1ns/1ns
// ============================================================
// Cache flush responder, slow on purpose
module flush_model #(
  parameter int DELAY = 5
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  output logic done_o
);
  int cnt;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 0;
      done_o <= 1'b0;
    end else begin
      cnt <= req_i ? cnt + 1 : 0;
      done_o <= req_i && cnt == DELAY;
    end
  end
endmodule // flush_model

// ### seek_feature_exec_bench.sv
`timescale 1ns/1ns
// ============================================================
// Command block bench
module seek_feature_exec_bench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, d;
  logic rdy_w, fl_req, fl_done, lo, io16, wc, iordy, apm, stby, busy, done, pl1, ext, rla, resp;
  logic saw_flush = 1'b0;
  logic [2:0] pio;
  logic [1:0] band;
  logic [7:0] lvl, xb, cur;
  int n_errors = 0;
  int checks_done = 0;

  initial forever #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (fl_req === 1'b1) saw_flush <= 1'b1;

  seek_feature_exec #(.ECC_BYTES(8'h0C)) i_seek_feature_exec (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(rdy_w), .hrdata_o(hrdata), .hreadyout_o(rdy_w), .hresp_o(resp), .flush_req_o(fl_req),
    .flush_done_i(fl_done), .data_lo_only_o(lo), .iois16_allow_o(io16), .wcache_en_o(wc), .pio_mode_o(pio),
    .iordy_en_o(iordy), .apm_en_o(apm), .apm_level_o(lvl), .apm_band_o(band), .standby_allow_o(stby),
    .pl1_en_o(pl1), .ext_pwr_en_o(ext), .rla_en_o(rla), .long_extra_bytes_o(xb), .cur_limit_o(cur),
    .busy_o(busy), .cmd_done_o(done));
  flush_model i_flush_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(fl_req), .done_o(fl_done));

  // ============================================================
  // Bus and compare helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Ready and read data taken at the edge
  task automatic rdy;
    do @(posedge clk_sys_i); while (rdy_w !== 1'b1);
    d = hrdata;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    rdy();
  endtask
  task automatic cmd(input logic [7:0] c);
    int n = 0;
    xfer(1'b1, 8'h18, c);
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (done !== 1'b1 && n < 50);
    chk(done, 1'b1);
    xfer(1'b0, 8'h00, 8'h00);
  endtask
  task automatic sf(input logic [7:0] f, input logic [7:0] c, input logic [7:0] e);
    xfer(1'b1, 8'h04, c);
    xfer(1'b1, 8'h00, f);
    cmd(8'hEF);
    chk(d, {24'h0, e});
  endtask
  task automatic srst;
    xfer(1'b1, 8'h1C, 8'h04);
    @(posedge clk_sys_i);
    chk(busy, 1'b1);
    xfer(1'b1, 8'h1C, 8'h00);
    repeat (2) @(posedge clk_sys_i);
  endtask

  // ============================================================
  // Scenarios
  task automatic t_toggles;
    logic [7:0] on_c[6] = '{8'h01, 8'h0A, 8'h09, 8'hAA, 8'h44, 8'h05};
    logic [7:0] off_c[6] = '{8'h81, 8'h8A, 8'h89, 8'h55, 8'hBB, 8'h85};
    int bp[6] = '{0, 7, 8, 9, 10, 6};
    xfer(1'b0, 8'h20, 8'h00);
    chk(d, 32'h19FE_0890);
    for (int i = 0; i < 6; i++) begin
      sf(on_c[i], 8'h80, 8'h00);
      xfer(1'b0, 8'h20, 8'h00);
      chk(d[bp[i]], 1'b1);
      if (i == 4) chk(xb, 8'h0C);
      sf(off_c[i], 8'h80, 8'h00);
      xfer(1'b0, 8'h20, 8'h00);
      chk(d[bp[i]], 1'b0);
    end
    chk(xb, 8'h04);
    chk({resp, pl1, ext, rla}, 4'h0);
    $display("test toggles done");
  endtask
  task automatic t_nops;
    logic [31:0] c0;
    logic [7:0] f[5] = '{8'h69, 8'h96, 8'h97, 8'h33, 8'h00};
    xfer(1'b0, 8'h20, 8'h00);
    c0 = d;
    for (int i = 0; i < 5; i++) sf(f[i], 8'h80, (i < 3) ? 8'h00 : 8'h04);
    xfer(1'b0, 8'h20, 8'h00);
    chk(d, c0);
    $display("test nops done");
  endtask
  task automatic t_tables;
    logic [19:0] xt[6] = '{20'h0C041, 20'h0D441, 20'h0B031, 20'h01000, 20'h10400, 20'h00001};
    logic [19:0] at[6] = '{20'h01001, 20'h7F011, 20'h80020, 20'hFE030, 20'h00430, 20'hFF430};
    foreach (xt[i]) begin
      sf(8'h03, xt[i][19:12], {4'h0, xt[i][11:8]});
      chk({pio, iordy}, {xt[i][6:4], xt[i][0]});
    end
    foreach (at[i]) begin
      sf(8'h05, at[i][19:12], {4'h0, at[i][11:8]});
      chk({band, stby}, {at[i][5:4], at[i][0]});
    end
    chk(lvl, 8'hFE);
    sf(8'h85, 8'h00, 8'h00);
    chk({apm, stby}, 2'h1);
    $display("test tables done");
  endtask
  task automatic t_cur;
    logic [15:0] ct[3] = '{16'h0606, 16'h0105, 16'hFF19};
    foreach (ct[i]) begin
      sf(8'h9A, ct[i][15:8], 8'h00);
      chk(cur, ct[i][7:0]);
    end
    xfer(1'b0, 8'h0C, 8'h00);
    chk(d, 32'h05);
    xfer(1'b0, 8'h10, 8'h00);
    chk(d, 32'h19);
    $display("test current done");
  endtask
  task automatic t_flush_seek;
    sf(8'h02, 8'h00, 8'h00);
    chk(wc, 1'b1);
    sf(8'h82, 8'h00, 8'h00);
    chk({saw_flush, wc}, 2'h2);
    xfer(1'b1, 8'h14, 8'h40);
    xfer(1'b1, 8'h10, 8'h7F);
    xfer(1'b1, 8'h0C, 8'hFF);
    xfer(1'b1, 8'h08, 8'hFF);
    cmd(8'h70);
    chk(d, 32'h00);
    xfer(1'b1, 8'h10, 8'h80);
    cmd(8'h7F);
    chk(d, 32'h10);
    xfer(1'b0, 8'h18, 8'h00);
    chk(d[0], 1'b1);
    xfer(1'b1, 8'h14, 8'h0F);
    xfer(1'b1, 8'h10, 8'h03);
    xfer(1'b1, 8'h08, 8'h20);
    cmd(8'h71);
    chk(d, 32'h00);
    $display("test flush seek done");
  endtask
  task automatic t_srst;
    sf(8'h66, 8'h00, 8'h00);
    sf(8'h01, 8'h00, 8'h00);
    chk({lo, io16}, 2'h2);
    srst();
    chk(lo, 1'b1);
    sf(8'hCC, 8'h00, 8'h00);
    srst();
    chk(lo, 1'b0);
    $display("test soft reset done");
  endtask

  // ============================================================
  // Run and verdict
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_toggles();
    t_nops();
    t_tables();
    t_cur();
    t_flush_seek();
    t_srst();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_errors++;
    tally_and_finish();
  end
endmodule // seek_feature_exec_bench
